// File: pppe_pkg.sv
package pppe_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TXHDR = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_GROUP = 8'h0C;
  localparam logic [7:0] REG_PHYLO = 8'h10;
  localparam logic [7:0] REG_PHYHI = 8'h14;
  localparam logic [7:0] REG_TXDST = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_RXHDR = 8'h20;
  localparam logic [7:0] REG_RXSRC = 8'h24;
  localparam logic [7:0] REG_TXDATA = 8'h28;
  localparam logic [7:0] REG_RXDATA = 8'h2C;
  localparam logic [7:0] REG_TXDSTHI = 8'h30;

  // ----------------------------------------------------------------
  // ctrl fields
  // ----------------------------------------------------------------
  localparam int CTRL_GO = 0;
  localparam int CTRL_EXTADDR = 1;
  localparam int CTRL_LOCK = 2;
  localparam int CTRL_TXEN = 3;
  localparam int CTRL_RETRY_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0008;

  // ----------------------------------------------------------------
  // status fields (bits 0 to 7 write one to clear, busy bit 8 read only)
  // ----------------------------------------------------------------
  localparam int ST_RXNEW = 0;
  localparam int ST_TXDONE = 1;
  localparam int ST_NOACK = 2;
  localparam int ST_NORESP = 3;
  localparam int ST_RESPOK = 4;
  localparam int ST_CFGCHG = 5;
  localparam int ST_HDRERR = 6;
  localparam int ST_CRCERR = 7;
  localparam int ST_BUSY = 8;

  // ----------------------------------------------------------------
  // packet constants
  // ----------------------------------------------------------------
  localparam logic [7:0] PREAMBLE = 8'hAB;
  localparam logic [1:0] DA_LOGICAL = 2'h0;
  localparam logic [1:0] DA_GROUP = 2'h1;
  localparam logic [1:0] DA_PHYSICAL = 2'h2;
  localparam logic SA_LOGICAL = 1'h0;
  localparam logic SA_PHYSICAL = 1'h1;
  localparam logic [7:0] BROADCAST_GROUP = 8'h00;
  localparam int HDR_MIN = 6;
  localparam int HDR_MAX = 20;
  localparam int PAY_MAX = 31;
  localparam logic [3:0] HCRC_POLY = 4'h3;
  localparam logic [3:0] HCRC_INIT = 4'h0;
  localparam logic [7:0] PCRC_POLY = 8'h07;
  localparam logic [7:0] PCRC_INIT = 8'h00;
  localparam logic [7:0] CMD_SEND_DATA = 8'h09;
  localparam logic [7:0] CMD_REQ_DATA = 8'h0A;
  localparam logic [7:0] CMD_RESP_DATA = 8'h0B;
  localparam logic [7:0] CMD_SET_TXEN = 8'h01;
  localparam logic [7:0] CMD_SET_EXT = 8'h03;
  localparam logic [7:0] CMD_SET_LADDR = 8'h04;
  localparam logic [7:0] RESP_OK = 8'h00;
  localparam logic [7:0] RESP_DENIED = 8'h01;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int ACK_WAIT_MS = 500;
  localparam int RESP_WAIT_US = 1500000;
  localparam int ACK_CYCLES = ACK_WAIT_MS * 1000 * CLK_MHZ;
  localparam int RESP_CYCLES = 375000000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } pppe_byte_t;

  typedef enum logic [1:0] {SVC_UNACK, SVC_ACK, SVC_R2, SVC_R3} pppe_svc_t;

endpackage

// File: pppe_engine.sv
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// Notes on behaviour
// RL1 - header six bytes, twenty with physical
// RL2 - reserved header bits sent as zero
// RL3 - source kind zero logical, one physical
// RL4 - dest kind logical, group, physical only
// RL5 - service bit zero unacked, one acked
// RL6 - reply marker set on acks/responses
// RL7 - four-bit sequence tag in header
// RL8 - header CRC, abandon on mismatch
// RL9 - payload zero to thirty-one bytes
// RL10 - final byte packet CRC over all
// RL11 - new packet advances sequence tag
// RL12 - acked retry keeps same tag
// RL13 - unacked sent retry plus one times
// RL14 - duplicates hidden from host, still acked; code still sets CFGCHG and reapplies duplicate control commands
// RL15 - 8/16-bit logical, fixed 64-bit physical
// RL16 - one of 256 single groups
// RL17 - eight multiple groups, combinable
// RL18 - group zero is broadcast
// RL19 - group addressing forces unacknowledged
// RL20 - control commands auto processed, answered
// RL21 - data commands acked, 500ms ack wait
// RL22 - data request waits 1.5s response
// RL23 - preamble byte before each packet
// RL24 - config answer success or denied
// RL25 - fixed CRC polynomials and seeds
module pppe_engine
  import pppe_pkg::*;
#(
  parameter logic [63:0] PHYS_ADDR = 64'h0123_4567_89AB_CDEF,
  parameter int ACK_WAIT = ACK_CYCLES,
  parameter int RESP_WAIT = RESP_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // line byte stream out
  output pppe_byte_t txByte,
  input wire logic txReady,
  // line byte stream in
  input wire pppe_byte_t rxByte
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] txHdr;
  logic [15:0] logAddr;
  logic [15:0] groupCfg;
  logic [63:0] txDst;
  logic [8:0] status;
  logic [31:0] rxHdr;
  logic [63:0] rxSrc;
  logic [7:0] txMem [0:PAY_MAX-1];
  logic [7:0] rxMem [0:PAY_MAX-1];
  logic [4:0] txWr;
  logic [4:0] rxRd;
  logic [3:0] seqTag;
  logic [3:0] retryLeft;
  logic [31:0] waitCnt;
  logic waitAck;
  logic waitResp;
  logic [3:0] lastSeq;
  logic [7:0] lastCrc;
  logic [63:0] lastSrc;
  logic hasLast;

  wire logic wrEn = psel && penable && pwrite;
  wire logic rdEn = psel && penable && !pwrite;
  logic hit;
  logic [8:0] setBits;

  // txHdr: [7:0] cmd [12:8] len [14:13] dakind [15] sakind [16] svc
  wire logic [7:0] txCmd = txHdr[7:0];
  wire logic [4:0] txLen = txHdr[12:8];
  wire logic [1:0] txDaKind = txHdr[14:13];
  wire logic txSaKind = txHdr[15];
  // group use forces unacked
  // RL19 force unacked
  wire logic txSvc = txHdr[16] && (txDaKind != DA_GROUP);
  wire logic extAddr = ctrl[CTRL_EXTADDR];

  // ----------------------------------------------------------------
  // crc helpers
  // ----------------------------------------------------------------
  // RL25 fixed polynomials
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ PCRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic [3:0] crc4(input logic [3:0] c, input logic [7:0] d);
    logic [3:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[3] ^ d[i]) ? ((r << 1) ^ HCRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // apb
  // ----------------------------------------------------------------
  assign pready = 1'b1;

  always_comb begin
    hit = 1'b1;
    prdata = 32'h0000_0000;
    if (paddr == REG_CTRL) begin
      prdata = ctrl;
    end else if (paddr == REG_TXHDR) begin
      prdata = txHdr;
    end else if (paddr == REG_ADDR) begin
      prdata = {16'h0000, logAddr};
    end else if (paddr == REG_GROUP) begin
      prdata = {16'h0000, groupCfg};
    end else if (paddr == REG_PHYLO) begin
      prdata = PHYS_ADDR[31:0];
    end else if (paddr == REG_PHYHI) begin
      prdata = PHYS_ADDR[63:32];
    end else if (paddr == REG_TXDST) begin
      prdata = txDst[31:0];
    end else if (paddr == REG_TXDSTHI) begin
      prdata = txDst[63:32];
    end else if (paddr == REG_STATUS) begin
      prdata = {23'h000000, status};
    end else if (paddr == REG_RXHDR) begin
      prdata = rxHdr;
    end else if (paddr == REG_RXSRC) begin
      prdata = rxSrc[31:0];
    end else if (paddr == REG_TXDATA) begin
      prdata = {27'h0000000, txWr};
    end else if (paddr == REG_RXDATA) begin
      prdata = {24'h000000, rxMem[rxRd]};
    end else begin
      hit = 1'b0;
    end
  end
  assign pslverr = psel && penable && !hit;

  // ----------------------------------------------------------------
  // transmit state machine
  // ----------------------------------------------------------------
  typedef enum {TX_IDLE, TX_PRE, TX_HDR, TX_PAY, TX_CRC, TX_GAP} pppe_tx_state_t;
  pppe_tx_state_t txState;
  logic [4:0] idx;
  logic [7:0] hdrBuf [0:HDR_MAX-1];
  logic [4:0] hdrLen;
  logic [7:0] pcrc;
  logic txIsReply;
  logic [7:0] replyCmd;
  logic [7:0] replyData;
  logic replyPend;
  logic [63:0] replyDst;
  logic replyPhys;
  logic txStart;
  logic [3:0] hc;
  logic [7:0] b0;
  logic [4:0] dLen;
  logic [4:0] sLen;

  // header assembly
  always_comb begin
    for (int i = 0; i < HDR_MAX; i++) begin
      hdrBuf[i] = 8'h00;
    end
    // RL3 RL4 RL5 RL6 RL2 byte zero
    b0 = {txIsReply ? replyPhys : txSaKind,
          txIsReply ? (replyPhys ? DA_PHYSICAL : DA_LOGICAL) :
            ((txDaKind == 2'h3) ? DA_LOGICAL : txDaKind),
          txIsReply ? 1'b0 : txSvc, 2'b00, txIsReply, 1'b0};
    hdrBuf[0] = b0;
    // RL1 address lengths
    dLen = b0[6:5] == DA_PHYSICAL ? 5'd8 : (extAddr && b0[6:5] == DA_LOGICAL ? 5'd2 : 5'd1);
    sLen = b0[7] ? 5'd8 : (extAddr ? 5'd2 : 5'd1);
    for (int i = 0; i < 8; i++) begin
      if (i < dLen) begin
        hdrBuf[1 + i] = txIsReply ? replyDst[8*i +: 8] : txDst[8*i +: 8];
      end
      if (i < sLen) begin
        hdrBuf[5'(1 + i) + dLen] = b0[7] ? PHYS_ADDR[8*i +: 8] : (i == 0 ? logAddr[7:0] : logAddr[15:8]);
      end
    end
    hdrLen = dLen + sLen + 5'd4;
    hdrBuf[hdrLen - 5'd3] = txIsReply ? replyCmd : txCmd;
    // RL9 RL2 length byte
    hdrBuf[hdrLen - 5'd2] = {3'b000, txIsReply ? 5'd1 : txLen};
    hc = HCRC_INIT;
    for (int i = 0; i < HDR_MAX - 1; i++) begin
      if (i < hdrLen - 1) begin
        hc = crc4(hc, hdrBuf[i]);
      end
    end
    // RL7 RL8 tag and header crc
    hdrBuf[hdrLen - 5'd1] = {seqTag, crc4(hc, {seqTag, 4'h0})};
  end

  assign txStart = txState == TX_IDLE && (replyPend || (ctrl[CTRL_GO] && ctrl[CTRL_TXEN]));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txState <= TX_IDLE;
      idx <= 5'd0;
      pcrc <= PCRC_INIT;
      txByte <= '0;
      txIsReply <= 1'b0;
    end else begin
      if (txReady || !txByte.valid) begin
        txByte <= '0;
        case (txState)
          TX_IDLE: begin
            if (txStart) begin
              txIsReply <= replyPend;
              txState <= TX_PRE;
            end
          end
          TX_PRE: begin
            // RL23 preamble
            txByte <= '{valid: 1'b1, data: PREAMBLE, last: 1'b0};
            idx <= 5'd0;
            pcrc <= PCRC_INIT;
            txState <= TX_HDR;
          end
          TX_HDR: begin
            txByte <= '{valid: 1'b1, data: hdrBuf[idx], last: 1'b0};
            pcrc <= crc8(pcrc, hdrBuf[idx]);
            idx <= idx + 5'd1;
            if (idx == hdrLen - 5'd1) begin
              idx <= 5'd0;
              txState <= (txIsReply ? 5'd1 : txLen) == 5'd0 ? TX_CRC : TX_PAY;
            end
          end
          TX_PAY: begin
            txByte <= '{valid: 1'b1, data: txIsReply ? replyData : txMem[idx], last: 1'b0};
            pcrc <= crc8(pcrc, txIsReply ? replyData : txMem[idx]);
            idx <= idx + 5'd1;
            if (txIsReply || idx == txLen - 5'd1) begin
              txState <= TX_CRC;
            end
          end
          TX_CRC: begin
            // RL10 trailing crc
            txByte <= '{valid: 1'b1, data: pcrc, last: 1'b1};
            txState <= TX_GAP;
          end
          default: begin
            txState <= TX_IDLE;
          end
        endcase
      end
    end
  end
  wire logic txEnd = txState == TX_GAP && (txReady || !txByte.valid);

  // ----------------------------------------------------------------
  // receive parser
  // ----------------------------------------------------------------
  logic [4:0] rIdx;
  logic [7:0] rB0;
  logic [4:0] rDLen;
  logic [4:0] rSLen;
  logic [4:0] rLen;
  logic [3:0] rHc;
  logic [7:0] rPc;
  logic [63:0] rDst;
  logic [63:0] rSrcW;
  logic [7:0] rCmd;
  logic [3:0] rSeq;
  logic rAbort;
  logic [4:0] rPay;
  logic rInPay;
  logic [7:0] rFirst;
  wire logic [4:0] rHdrLen = rDLen + rSLen + 5'd4;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rIdx <= 5'd0;
      rB0 <= 8'h00;
      rDLen <= 5'd1;
      rSLen <= 5'd1;
      rLen <= 5'd0;
      rHc <= HCRC_INIT;
      rPc <= PCRC_INIT;
      rDst <= '0;
      rSrcW <= '0;
      rCmd <= 8'h00;
      rSeq <= 4'h0;
      rAbort <= 1'b0;
      rPay <= 5'd0;
      rInPay <= 1'b0;
      rFirst <= 8'h00;
    end else if (rxByte.valid) begin
      rPc <= crc8(rPc, rxByte.data);
      if (rxByte.last) begin
        rIdx <= 5'd0;
        rInPay <= 1'b0;
        rAbort <= 1'b0;
        rHc <= HCRC_INIT;
        rPc <= PCRC_INIT;
        rPay <= 5'd0;
      end else if (!rInPay) begin
        rIdx <= rIdx + 5'd1;
        if (rIdx == 5'd0) begin
          rB0 <= rxByte.data;
          rDLen <= rxByte.data[6:5] == DA_PHYSICAL ? 5'd8 : (extAddr && rxByte.data[6:5] != DA_GROUP ? 5'd2 : 5'd1);
          rSLen <= rxByte.data[7] ? 5'd8 : (extAddr ? 5'd2 : 5'd1);
          rDst <= '0;
          rSrcW <= '0;
        end else if (rIdx <= rDLen) begin
          rDst[8*(rIdx-5'd1) +: 8] <= rxByte.data;
        end else if (rIdx <= rDLen + rSLen) begin
          rSrcW[8*(rIdx-5'd1-rDLen) +: 8] <= rxByte.data;
        end else if (rIdx == rHdrLen - 5'd3) begin
          rCmd <= rxByte.data;
        end else if (rIdx == rHdrLen - 5'd2) begin
          rLen <= rxByte.data[4:0];
        end
        if (rIdx < rHdrLen - 5'd1) begin
          rHc <= crc4(rHc, rxByte.data);
        end else begin
          rSeq <= rxByte.data[7:4];
          // RL8 abandon on header mismatch
          rAbort <= crc4(rHc, {rxByte.data[7:4], 4'h0}) != rxByte.data[3:0];
          rInPay <= 1'b1;
        end
      end else if (rPay < rLen) begin
        if (rPay == 5'd0) begin
          rFirst <= rxByte.data;
        end
        rPay <= rPay + 5'd1;
      end
    end
  end

  // payload store written as bytes arrive, for every frame whether good or not
  logic rxFrameEnd;
  assign rxFrameEnd = rxByte.valid && rxByte.last;
  wire logic crcOk = rPc == rxByte.data;
  // RL15 RL16 RL17 RL18 address match
  logic groupHit;
  always_comb begin
    groupHit = rDst[7:0] == BROADCAST_GROUP || rDst[7:0] == groupCfg[7:0];
    for (int i = 0; i < 8; i++) begin
      if (groupCfg[8 + i] && rDst[7:0] == 8'(i + 1)) begin
        groupHit = 1'b1;
      end
    end
  end
  wire logic [1:0] rDa = rB0[6:5];
  wire logic addrHit = rDa == DA_GROUP ? groupHit :
    rDa == DA_PHYSICAL ? rDst == PHYS_ADDR :
    rDa == DA_LOGICAL ? rDst[15:0] == (extAddr ? logAddr : {8'h00, logAddr[7:0]}) : 1'b0;
  wire logic good = rxFrameEnd && !rAbort && crcOk && addrHit && rInPay;
  // RL14 duplicate test
  wire logic dup = hasLast && lastSeq == rSeq && lastCrc == rxByte.data && lastSrc == rSrcW;
  wire logic isReply = rB0[1];
  wire logic isCtrl = (rCmd >= 8'h01 && rCmd <= 8'h08) || (rCmd >= 8'h0C && rCmd <= 8'h0F);
  wire logic isData = rCmd == CMD_SEND_DATA || rCmd == CMD_REQ_DATA;

  always_ff @(posedge mclk) begin
    if (rxByte.valid && rInPay && !rxByte.last && rPay < rLen) begin
      rxMem[rPay] <= rxByte.data;
    end
    if (wrEn && paddr == REG_TXDATA) begin
      txMem[txWr] <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // control, sequencing, replies, timers
  // ----------------------------------------------------------------
  always_comb begin
    setBits = '0;
    setBits[ST_HDRERR] = rxFrameEnd && rAbort;
    setBits[ST_CRCERR] = rxFrameEnd && !rAbort && !crcOk;
    setBits[ST_RXNEW] = good && !isReply && !dup && isData;
    setBits[ST_CFGCHG] = good && !isReply && isCtrl && !ctrl[CTRL_LOCK];
    setBits[ST_RESPOK] = (good && waitResp && rCmd == CMD_RESP_DATA) || (good && waitAck && isReply);
    setBits[ST_NOACK] = waitAck && waitCnt == 32'd1 && retryLeft == 4'h0;
    setBits[ST_NORESP] = waitResp && waitCnt == 32'd1;
    setBits[ST_TXDONE] = txEnd && !txIsReply && retryLeft == 4'h0 && !txSvc;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= CTRL_RESET;
      txHdr <= '0;
      logAddr <= '0;
      groupCfg <= '0;
      txDst <= '0;
      status <= '0;
      rxHdr <= '0;
      rxSrc <= '0;
      txWr <= 5'd0;
      rxRd <= 5'd0;
      seqTag <= 4'h0;
      retryLeft <= 4'h0;
      waitCnt <= '0;
      waitAck <= 1'b0;
      waitResp <= 1'b0;
      lastSeq <= 4'h0;
      lastCrc <= 8'h00;
      lastSrc <= '0;
      hasLast <= 1'b0;
      replyPend <= 1'b0;
      replyCmd <= 8'h00;
      replyData <= 8'h00;
      replyDst <= '0;
      replyPhys <= 1'b0;
    end else begin
      if (wrEn) begin
        if (paddr == REG_CTRL) begin
          ctrl <= pwdata;
          retryLeft <= pwdata[CTRL_RETRY_LSB +: 4];
        end else if (paddr == REG_TXHDR) begin
          txHdr <= pwdata;
        end else if (paddr == REG_ADDR) begin
          logAddr <= pwdata[15:0];
        end else if (paddr == REG_GROUP) begin
          groupCfg <= pwdata[15:0];
        end else if (paddr == REG_TXDST) begin
          txDst[31:0] <= pwdata;
        end else if (paddr == REG_TXDSTHI) begin
          txDst[63:32] <= pwdata;
        end else if (paddr == REG_TXDATA) begin
          txWr <= txWr + 5'd1;
        end
      end
      if (rdEn && paddr == REG_RXDATA) begin
        rxRd <= rxRd + 5'd1;
      end
      // set wins over write-one clear
      status[7:0] <= (status[7:0] & ~((wrEn && paddr == REG_STATUS) ? pwdata[7:0] : 8'h00))
        | setBits[7:0];
      status[ST_BUSY] <= txState != TX_IDLE || ctrl[CTRL_GO] || waitAck || waitResp;
      if (txStart && !replyPend) begin
        ctrl[CTRL_GO] <= 1'b0;
        txWr <= 5'd0;
      end
      if (txEnd && txIsReply) begin
        replyPend <= 1'b0;
      end
      if (txEnd && !txIsReply) begin
        if (txSvc) begin
          waitAck <= 1'b1;
          waitCnt <= 32'(ACK_WAIT);
        end else if (retryLeft != 4'h0) begin
          // RL13 repeat same tag
          retryLeft <= retryLeft - 4'h1;
          ctrl[CTRL_GO] <= 1'b1;
        end else begin
          // RL11 advance tag
          seqTag <= seqTag + 4'h1;
          retryLeft <= ctrl[CTRL_RETRY_LSB +: 4];
          if (txCmd == CMD_REQ_DATA) begin
            waitResp <= 1'b1;
            waitCnt <= 32'(RESP_WAIT);
          end
        end
      end
      if (waitCnt != 32'd0 && (waitAck || waitResp)) begin
        waitCnt <= waitCnt - 32'd1;
      end
      // RL21 ack wait
      if (waitAck && (waitCnt == 32'd1 || (good && isReply))) begin
        waitAck <= 1'b0;
        if (good && isReply) begin
          seqTag <= seqTag + 4'h1;
          retryLeft <= ctrl[CTRL_RETRY_LSB +: 4];
          if (txCmd == CMD_REQ_DATA) begin
            waitResp <= 1'b1;
            waitCnt <= 32'(RESP_WAIT);
          end
        end else if (retryLeft != 4'h0) begin
          // RL12 acked retransmit
          retryLeft <= retryLeft - 4'h1;
          ctrl[CTRL_GO] <= 1'b1;
        end else begin
          seqTag <= seqTag + 4'h1;
        end
      end
      // RL22 response wait
      if (waitResp && (waitCnt == 32'd1 || (good && rCmd == CMD_RESP_DATA))) begin
        waitResp <= 1'b0;
      end
      if (good && !isReply) begin
        rxHdr <= {rSeq, rLen, 3'b000, rB0, rCmd, 4'h0};
        rxSrc <= rSrcW;
        if (!dup) begin
          rxRd <= 5'd0;
        end
        hasLast <= 1'b1;
        lastSeq <= rSeq;
        lastCrc <= rxByte.data;
        lastSrc <= rSrcW;
        replyDst <= rSrcW;
        replyPhys <= rB0[7];
        replyCmd <= rCmd;
        // RL14 RL21 ack data, dup too
        if (isData && rB0[4] && rDa != DA_GROUP) begin
          replyPend <= 1'b1;
          replyData <= RESP_OK;
        end
        // RL20 RL24 control answer
        if (isCtrl && rDa != DA_GROUP) begin
          replyPend <= 1'b1;
          replyData <= ctrl[CTRL_LOCK] ? RESP_DENIED : RESP_OK;
        end
        if (isCtrl && !ctrl[CTRL_LOCK]) begin
          if (rCmd == CMD_SET_TXEN) begin
            ctrl[CTRL_TXEN] <= rFirst[0];
          end else if (rCmd == CMD_SET_EXT) begin
            ctrl[CTRL_EXTADDR] <= rFirst[0];
          end else if (rCmd == CMD_SET_LADDR) begin
            logAddr <= {8'h00, rFirst};
          end
        end
      end
    end
  end

endmodule

// File: pppe_checker.sv
`timescale 1ns/100ps
module pppe_checker
  import pppe_pkg::*;
(
  // clock, reset
  input wire logic mclk,
  input wire logic resetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // line
  input wire pppe_byte_t txByte,
  input wire logic txReady
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ---
  // byte index in frame
  // ---
  logic [5:0] idx;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      idx <= '0;
    end else if (txByte.valid && txReady) begin
      idx <= txByte.last ? '0 : idx + 6'h01;
    end
  end
  ready_now_a: assert property (psel && penable |-> pready)
    else $error("no ready");
  err_cause_a: assert property (pslverr |-> psel && penable)
    else $error("stray slave error");
  err_unmapped_a: assert property (psel && penable && paddr > 8'h30 |-> pslverr)
    else $error("unmapped not refused");
  tx_hold_a: assert property (txByte.valid && !txReady |=> txByte.valid && $stable(txByte))
    else $error("byte dropped");
  reset_idle_a: assert property ($rose(resetn) |-> !txByte.valid)
    else $error("busy out of reset");
  preamble_a: assert property (txByte.valid && idx == 6'h00 |-> txByte.data == PREAMBLE)
    else $error("bad preamble");
  hdr_bits_a: assert property (txByte.valid && idx == 6'h01 |->
    txByte.data[3:2] == 2'h0 && !txByte.data[0] && txByte.data[6:5] != 2'h3)
    else $error("bad header bits");
  group_unack_a: assert property (txByte.valid && idx == 6'h01 &&
    txByte.data[6:5] == DA_GROUP |-> !txByte.data[4])
    else $error("group acked");
  pkt_len_a: assert property (txByte.valid && txByte.last |->
    idx >= 6'h07 && idx <= 6'h34)
    else $error("bad frame length");
endmodule
bind pppe_engine pppe_checker checker_u (.mclk, .resetn, .psel, .penable, .paddr, .pready,
  .pslverr, .txByte, .txReady);

// File: pppe_remote_node.sv
`timescale 1ns/100ps
module pppe_remote_node
  import pppe_pkg::*;
(
  // clock, reset
  input wire logic mclk,
  input wire logic resetn,
  // line
  input wire pppe_byte_t txByte,
  output logic txReady,
  output pppe_byte_t rxByte,
  // stall control
  input wire logic slow
);
  logic [7:0] q[$];
  logic busy = 1'b0;
  initial begin
    txReady = 1'b0;
    rxByte = '0;
  end
  // ---
  // capture and idle line
  // ---
  always @(posedge mclk) begin
    txReady <= resetn && (!slow || !txReady);
    if (txByte.valid && txReady) begin
      q.push_back(txByte.data);
    end
    if (!busy) begin
      rxByte <= '{1'b0, ~rxByte.data, 1'b0};
    end
  end
  task automatic send(input logic [7:0] b[]);
    busy <= 1'b1;
    foreach (b[i]) begin
      @(posedge mclk);
      rxByte <= '{1'b1, b[i], i == b.size() - 1};
    end
    busy <= 1'b0;
  endtask
endmodule

// File: tb_pppe_engine.sv
`timescale 1ns/100ps
module tb_pppe_engine
  import pppe_pkg::*;
;
  logic mclk, resetn, psel, penable, pwrite, pready, pslverr, txReady, slow, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] s1, s2;
  pppe_byte_t txByte, rxByte;
  int n_fail = 0;
  int samples_checked = 0;
  pppe_engine #(.PHYS_ADDR(64'h0011_2233_4455_6677), .ACK_WAIT(50), .RESP_WAIT(50)) dut_u (
    .mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .txByte, .txReady, .rxByte);
  pppe_remote_node partner_u (.mclk, .resetn, .txByte, .txReady, .rxByte, .slow);
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    c = c ^ d;
    repeat (8) c = c[7] ? (c << 1) ^ PCRC_POLY : c << 1;
    return c;
  endfunction
  function automatic logic [3:0] crc4(input logic [3:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = (c[3] ^ d[i]) ? (c << 1) ^ HCRC_POLY : c << 1;
    return c;
  endfunction
  task send_chk(input logic [31:0] h, input logic [31:0] c, input int nf, input int sz,
    input logic [7:0] b0, output logic [3:0] sq);
    int k, b, s;
    logic [7:0] crc;
    logic [3:0] hc;
    partner_u.q.delete();
    apb(1'b1, REG_TXHDR, h);
    apb(1'b1, REG_TXDATA, 32'h11);
    apb(1'b1, REG_TXDATA, 32'h22);
    apb(1'b1, REG_CTRL, c);
    k = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      k++;
    end while (rd[ST_BUSY] !== 1'b0 && k < 500);
    chk(32'(partner_u.q.size()), 32'(nf * sz));
    for (int f = 0; f < nf; f++) begin
      b = f * sz;
      s = b + sz - 2 - int'(h[12:8]);
      crc = PCRC_INIT;
      for (int i = 1; i < sz - 1; i++) crc = crc8(crc, partner_u.q[b + i]);
      chk(partner_u.q[b], PREAMBLE);
      chk(partner_u.q[b + 1], b0);
      chk(partner_u.q[b + sz - 1], crc);
      hc = HCRC_INIT;
      for (int i = b + 1; i < s; i++) hc = crc4(hc, partner_u.q[i]);
      chk(partner_u.q[s][3:0], crc4(hc, {partner_u.q[s][7:4], 4'h0}));
      if (f > 0) chk(partner_u.q[s][7:4], sq);
      sq = partner_u.q[s][7:4];
    end
  endtask
  task t_regs();
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    apb(1'b0, REG_PHYHI, 32'h0);
    chk(rd, 32'h0011_2233);
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk(err, 1'b1);
  endtask
  task t_seq();
    apb(1'b1, REG_ADDR, 32'h07);
    apb(1'b1, REG_TXDST, 32'h05);
    send_chk(32'h0000_0209, 32'h09, 1, 10, 8'h00, s1);
    send_chk(32'h0000_0209, 32'h29, 3, 10, 8'h00, s2);
    chk(s2, s1 + 4'h1);
  endtask
  task t_kinds();
    apb(1'b1, REG_TXDST, 32'h0);
    send_chk(32'h0000_C009, 32'h09, 1, 22, 8'hC0, s1);
    slow <= 1'b1;
    send_chk(32'h0001_2009, 32'h09, 1, 8, 8'h20, s2);
    slow <= 1'b0;
  endtask
  task t_rx();
    apb(1'b1, REG_STATUS, 32'hFF);
    partner_u.send('{8'h00, 8'h07, 8'h05, 8'h09, 8'h00, 8'h00, 8'h5A});
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[ST_RXNEW], 1'b0);
    chk(rd[ST_HDRERR] | rd[ST_CRCERR], 1'b1);
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    slow = 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_seq();
    t_kinds();
    t_rx();
    print_verdict();
  end
endmodule
